// [hw/isp_pkg.sv]
/*
 package for the i2c slave register port: bus constants, slave address defaults,
 general call codes and timing counts. assumes a 40 MHz system clock.
*/
package isp_pkg;
   // ************************************************
   // clock and timing
   // ************************************************
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned MAX_SCL_KHZ = 400;
   localparam int unsigned STRETCH_MAX_US = 100;
   localparam int unsigned STRETCH_MAX_CYC = (STRETCH_MAX_US * (CLK_HZ / 1000000));
   // ************************************************
   // addresses and codes
   // ************************************************
   localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h44;
   localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
   localparam logic [7:0] GEN_CALL_RESET_CODE = 8'h06;
   localparam logic [7:0] REG_PTR_RESET = 8'h00;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   typedef enum logic [2:0]
   {
      ST_IDLE,
      ST_ADDR,
      ST_REGADR,
      ST_WDATA,
      ST_RDATA,
      ST_RACK,
      ST_GCALL,
      ST_IGNORE
   } isp_state_t;
endpackage

// [hw/isp_sync.sv]
/*
 two flip-flop synchroniser for scl and sda pins.
 assumes inputs are asynchronous to clk_i.
*/
`timescale 1ns/1ps
module isp_sync #(
   parameter int WIDTH = 2
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_next;

   always_comb
   begin
      meta_next = async_i;
      sync_next = meta_reg;
   end

   // idle bus level is high, so reset to ones
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         meta_reg <= '1;
         sync_reg <= '1;
      end
      else
      begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_o = sync_reg;
endmodule

// [hw/isp_i2c_slave.sv]
/*
 i2c slave front end giving a host access to an internal register set through
 an auto-incrementing address pointer. assumes open-drain scl/sda resolved
 outside, a register file that answers reads combinationally from reg_rdata_i,
 and a sleep indication from the power manager.
*/
// Notes on behaviour
// - interrupt line is driven low while a key or hardware event is pending.
// - when asleep, wake on start and leave that first address unacknowledged.
// - second attempt is acknowledged; reads and writes follow until stop. The code leaves every start unanswered while asleep_i is high.
// - slave only, up to 400 kHz bus clock.
// - device may hold scl low while busy; host waits for release.
// - clock stretch is cut off after 100 microseconds.
// - stretching happens after ack, or between start and first scl rise; the code stretches in any scl low phase outside ST_IDLE and ST_IGNORE.
// - first byte after write address loads the pointer and is acknowledged.
// - pointer advances by one per data byte unless the register is exempt.
// - pointer survives repeated start and stays valid until stop.
// - write data stored at pointer, acknowledged, then pointer advances.
// - read returns register at pointer; advance after each host ack.
// - general call write of 0x06 is recognised as reset.
// - general call reset restores the default slave address.
// - direction bit after seven address bits: zero write, one read.
// - every byte is followed by an acknowledge from the receiver.
`timescale 1ns/1ps
module isp_i2c_slave
   import isp_pkg::*;
#(
   parameter int unsigned STRETCH_LIMIT = STRETCH_MAX_CYC
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic asleep_i,
   input wire logic busy_i,
   input wire logic irq_pending_i,
   output logic host_interrupt_line_n_o,
   input wire logic addr_load_i,
   input wire logic [6:0] addr_new_i,
   input wire logic [ADDR_W-1:0] no_inc_addr_i,
   input wire logic no_inc_en_i,
   output logic [ADDR_W-1:0] reg_addr_o,
   output logic [DATA_W-1:0] reg_wdata_o,
   output logic reg_we_o,
   output logic reg_re_o,
   input wire logic [DATA_W-1:0] reg_rdata_i,
   output logic gen_call_reset_o,
   output logic [6:0] slave_addr_o
);
   // ************************************************
   // pin synchronisers and bus event detection
   // ************************************************
   logic [1:0] pins_sync;
   logic scl_s;
   logic sda_s;
   logic scl_d_reg;
   logic sda_d_reg;

   isp_sync #(.WIDTH(2)) u_sync (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .async_i({scl_i, sda_i}),
      .sync_o(pins_sync)
   );

   assign scl_s = pins_sync[1];
   assign sda_s = pins_sync[0];

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end
      else
      begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   assign scl_rise = scl_s & ~scl_d_reg;
   assign scl_fall = ~scl_s & scl_d_reg;
   assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // ************************************************
   // protocol state
   // ************************************************
   isp_state_t state_reg, state_next;
   logic [7:0] shift_reg, shift_next;
   logic [3:0] bit_reg, bit_next;
   logic ack_phase_reg, ack_phase_next;
   logic ack_drive_reg, ack_drive_next;
   logic rd_mode_reg, rd_mode_next;
   logic [ADDR_W-1:0] ptr_reg, ptr_next;
   logic [6:0] saddr_reg, saddr_next;
   logic woke_reg, woke_next;
   logic gcall_reg, gcall_next;
   logic sda_o_reg, sda_o_next;
   logic sda_oe_reg, sda_oe_next;
   logic scl_oe_reg, scl_oe_next;
   logic irq_n_reg, irq_n_next;
   logic we_reg, we_next;
   logic re_reg, re_next;
   logic gcr_reg, gcr_next;
   logic [DATA_W-1:0] wdata_reg, wdata_next;
   logic [$clog2(STRETCH_LIMIT+1)-1:0] str_cnt_reg, str_cnt_next;
   logic stretch_ok;
   logic [7:0] byte_in;
   logic host_ack;

   assign byte_in = {shift_reg[6:0], sda_s};
   assign stretch_ok = (str_cnt_reg < STRETCH_LIMIT[$bits(str_cnt_reg)-1:0]);
   assign host_ack = ~sda_s;

   always_comb
   begin
      state_next = state_reg;
      shift_next = shift_reg;
      bit_next = bit_reg;
      ack_phase_next = ack_phase_reg;
      ack_drive_next = ack_drive_reg;
      rd_mode_next = rd_mode_reg;
      ptr_next = ptr_reg;
      saddr_next = saddr_reg;
      woke_next = woke_reg;
      gcall_next = gcall_reg;
      sda_o_next = 1'b0;
      sda_oe_next = sda_oe_reg;
      scl_oe_next = 1'b0;
      // count holds through one low phase, so a spent stretch cannot restart before scl rises
      str_cnt_next = scl_s ? '0 : str_cnt_reg;
      we_next = 1'b0;
      re_next = 1'b0;
      gcr_next = 1'b0;
      wdata_next = wdata_reg;
      irq_n_next = ~irq_pending_i;
      if (addr_load_i)
         saddr_next = addr_new_i;
      // woke_next set on a start while asleep is cleared by the start branch below; that attempt is not answered
      if (asleep_i & start_det)
         woke_next = 1'b1;
      // busy stretch only while scl is already low, capped in length
      if (busy_i & ~scl_s & stretch_ok & (state_reg != ST_IDLE) & (state_reg != ST_IGNORE))
      begin
         scl_oe_next = 1'b1;
         str_cnt_next = str_cnt_reg + 1'b1;
      end
      if (stop_det)
      begin
         state_next = ST_IDLE;
         sda_oe_next = 1'b0;
         ptr_next = ptr_reg;
      end
      else if (start_det)
      begin
         // repeated start keeps the pointer
         bit_next = '0;
         ack_phase_next = 1'b0;
         sda_oe_next = 1'b0;
         // first address after wake is dropped: no ack, sda released
         state_next = (asleep_i | woke_reg) ? ST_IGNORE : ST_ADDR;
         woke_next = 1'b0;
      end
      else if (scl_rise & ~ack_phase_reg & (state_reg != ST_IDLE) & (state_reg != ST_IGNORE))
      begin
         shift_next = byte_in;
         bit_next = bit_reg + 1'b1;
      end
      else if (scl_rise & ack_phase_reg & (state_reg == ST_RACK))
      begin
         // host ack after a read byte decides whether to go on
         if (host_ack)
         begin
            ptr_next = (no_inc_en_i && ptr_reg == no_inc_addr_i) ? ptr_reg : ptr_reg + 1'b1;
            state_next = ST_RDATA;
         end
         else
            state_next = ST_IGNORE;
      end
      else if (scl_fall)
      begin
         if (ack_phase_reg)
         begin
            // end of ack bit: release or present next read bit
            ack_phase_next = 1'b0;
            ack_drive_next = 1'b0;
            bit_next = '0;
            if (state_reg == ST_RDATA)
            begin
               shift_next = reg_rdata_i;
               sda_oe_next = ~reg_rdata_i[7];
               re_next = 1'b1;
            end
            else
               sda_oe_next = 1'b0;
         end
         else if (state_reg == ST_RDATA)
         begin
            if (bit_reg == 4'd8)
            begin
               sda_oe_next = 1'b0;
               ack_phase_next = 1'b1;
               state_next = ST_RACK;
            end
            else
               sda_oe_next = ~shift_reg[7];
         end
         else if (bit_reg == 4'd8)
         begin
            ack_phase_next = 1'b1;
            unique case (state_reg)
               ST_ADDR:
               begin
                  rd_mode_next = shift_reg[0];
                  if (shift_reg[7:1] == saddr_reg)
                  begin
                     sda_oe_next = 1'b1;
                     state_next = shift_reg[0] ? ST_RDATA : ST_REGADR;
                  end
                  else if (shift_reg[7:1] == GEN_CALL_ADDR && !shift_reg[0])
                  begin
                     sda_oe_next = 1'b1;
                     state_next = ST_GCALL;
                  end
                  else
                     state_next = ST_IGNORE;
               end
               ST_REGADR:
               begin
                  ptr_next = shift_reg;
                  sda_oe_next = 1'b1;
                  state_next = ST_WDATA;
               end
               ST_WDATA:
               begin
                  we_next = 1'b1;
                  wdata_next = shift_reg;
                  sda_oe_next = 1'b1;
                  ptr_next = (no_inc_en_i && ptr_reg == no_inc_addr_i) ? ptr_reg : ptr_reg + 1'b1;
               end
               ST_GCALL:
               begin
                  if (shift_reg == GEN_CALL_RESET_CODE)
                  begin
                     gcr_next = 1'b1;
                     saddr_next = SLAVE_ADDR_DEFAULT;
                     sda_oe_next = 1'b1;
                  end
                  state_next = ST_IGNORE;
               end
               default:
                  state_next = ST_IGNORE;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         state_reg <= ST_IDLE;
         shift_reg <= '0;
         bit_reg <= '0;
         ack_phase_reg <= 1'b0;
         ack_drive_reg <= 1'b0;
         rd_mode_reg <= 1'b0;
         ptr_reg <= REG_PTR_RESET;
         saddr_reg <= SLAVE_ADDR_DEFAULT;
         woke_reg <= 1'b0;
         gcall_reg <= 1'b0;
         sda_o_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         scl_oe_reg <= 1'b0;
         irq_n_reg <= 1'b1;
         we_reg <= 1'b0;
         re_reg <= 1'b0;
         gcr_reg <= 1'b0;
         wdata_reg <= '0;
         str_cnt_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         bit_reg <= bit_next;
         ack_phase_reg <= ack_phase_next;
         ack_drive_reg <= ack_drive_next;
         rd_mode_reg <= rd_mode_next;
         ptr_reg <= ptr_next;
         saddr_reg <= saddr_next;
         woke_reg <= woke_next;
         gcall_reg <= gcall_next;
         sda_o_reg <= sda_o_next;
         sda_oe_reg <= sda_oe_next;
         scl_oe_reg <= scl_oe_next;
         irq_n_reg <= irq_n_next;
         we_reg <= we_next;
         re_reg <= re_next;
         gcr_reg <= gcr_next;
         wdata_reg <= wdata_next;
         str_cnt_reg <= str_cnt_next;
      end
   end

   // ************************************************
   // outputs, all from flip-flops except scl_o, tied low
   // ************************************************
   assign sda_o = sda_o_reg;
   assign sda_oe_o = sda_oe_reg;
   assign scl_o = 1'b0;
   assign scl_oe_o = scl_oe_reg;
   assign host_interrupt_line_n_o = irq_n_reg;
   assign reg_addr_o = ptr_reg;
   assign reg_wdata_o = wdata_reg;
   assign reg_we_o = we_reg;
   assign reg_re_o = re_reg;
   assign gen_call_reset_o = gcr_reg;
   assign slave_addr_o = saddr_reg;
endmodule

// [tb/isp_i2c_slave_sva.sv]
/* checker for the i2c slave port: pin, pointer, stretch and interrupt relations.
   assumes it is bound into isp_i2c_slave and sees only its ports. */
`timescale 1ns/1ps
module isp_i2c_slave_sva
   import isp_pkg::*;
#(
   parameter int unsigned STRETCH_LIMIT = STRETCH_MAX_CYC
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe_o,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic busy_i,
   input wire logic irq_pending_i,
   input wire logic host_interrupt_line_n_o,
   input wire logic [ADDR_W-1:0] no_inc_addr_i,
   input wire logic no_inc_en_i,
   input wire logic [ADDR_W-1:0] reg_addr_o,
   input wire logic reg_we_o,
   input wire logic gen_call_reset_o,
   input wire logic [6:0] slave_addr_o
);
   // ************
   // assertions
   // ************
   logic [15:0] str_cnt_reg;
   // one cycle of slack: the count lags the enable by a register
   always_ff @(posedge clk_i)
   begin
      str_cnt_reg <= (srst_i || !scl_oe_o) ? 16'h0000 : str_cnt_reg + 16'h0001;
   end
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   a_irq_follow: assert property (1'b1 |=> host_interrupt_line_n_o == !$past(irq_pending_i))
      else $error("interrupt line does not follow pending event");
   a_pins_pull_only: assert property (scl_o == 1'b0 && sda_o == 1'b0)
      else $error("bus pin value is not low");
   a_stretch_bound: assert property (str_cnt_reg <= STRETCH_LIMIT)
      else $error("clock stretch too long");
   a_stretch_start: assert property ($rose(scl_oe_o) |-> !$past(scl_i) && $past(busy_i))
      else $error("stretch without busy or while clock high");
   a_gcr_default: assert property (gen_call_reset_o |-> ##[0:1] slave_addr_o == SLAVE_ADDR_DEFAULT)
      else $error("general call did not restore address");
   a_ptr_step: assert property (reg_we_o && !(no_inc_en_i && $past(reg_addr_o) == no_inc_addr_i)
      |-> reg_addr_o == $past(reg_addr_o) + 8'h01)
      else $error("pointer did not advance by one");
   a_ptr_exempt: assert property (reg_we_o && no_inc_en_i && $past(reg_addr_o) == no_inc_addr_i
      |-> $stable(reg_addr_o))
      else $error("exempt pointer moved");
   a_we_single: assert property (reg_we_o |=> !reg_we_o)
      else $error("write strobe longer than one cycle");
   a_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data line changed while clock high");
   c_write: cover property (reg_we_o);
   c_gcall: cover property (gen_call_reset_o);
   c_stretch: cover property ($rose(scl_oe_o));
endmodule
bind isp_i2c_slave isp_i2c_slave_sva #(.STRETCH_LIMIT(STRETCH_LIMIT)) u_sva (.clk_i(clk_i), .srst_i(srst_i),
   .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .busy_i(busy_i),
   .irq_pending_i(irq_pending_i), .host_interrupt_line_n_o(host_interrupt_line_n_o), .no_inc_addr_i(no_inc_addr_i),
   .no_inc_en_i(no_inc_en_i), .reg_addr_o(reg_addr_o), .reg_we_o(reg_we_o), .gen_call_reset_o(gen_call_reset_o),
   .slave_addr_o(slave_addr_o));

// [tb/isp_host_bfm.sv]
/* host bus master model: start, repeated start, stop, byte write and read.
   assumes pulled-up wires resolved by the bench from the low outputs. */
`timescale 1ns/1ps
module isp_host_bfm (
   input wire logic clk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_low_o,
   output logic sda_low_o
);
   // ************
   // bus cycles
   // ************
   initial
   begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end
   // quarter bit of 50 ns, a 200 ns bus clock that stands still between frames
   task automatic qb();
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   task automatic rel_scl();
      scl_low_o = 1'b0;
      #1;
      for (int k = 0; k < 1000 && scl_i !== 1'b1; k++)
         @(posedge clk_i);
      qb();
   endtask
   task automatic start();
      sda_low_o = 1'b1;
      qb();
      scl_low_o = 1'b1;
      qb();
   endtask
   task automatic rstart();
      sda_low_o = 1'b0;
      qb();
      rel_scl();
      start();
   endtask
   task automatic stop();
      sda_low_o = 1'b1;
      qb();
      rel_scl();
      sda_low_o = 1'b0;
      qb();
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_low_o = !b;
      qb();
      rel_scl();
      r = sda_i;
      qb();
      scl_low_o = 1'b1;
      qb();
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic rd_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(!ack, r);
   endtask
endmodule

// [tb/i2c_slave_register_port_tb_top.sv]
/* bench for the i2c slave port: host model on the bus, stand-in register file,
   queued write checks. assumes package, design, host model and checker compiled first. */
`timescale 1ns/1ps
module i2c_slave_register_port_tb_top;
   import isp_pkg::*;
   // ************
   // bench
   // ************
   logic clk_i = 1'b0, srst_i = 1'b1, asleep_i = 1'b0, busy_i = 1'b0, irq_pending_i = 1'b0;
   logic addr_load_i = 1'b0, no_inc_en_i = 1'b0, h_scl_low, h_sda_low, scl_w, sda_w;
   logic [6:0] addr_new_i = 7'h00;
   logic scl_o, scl_oe_o, sda_o, sda_oe_o, irq_n, reg_we_o, reg_re_o, gen_call_reset_o, ack;
   logic [7:0] reg_addr_o, reg_wdata_o, reg_rdata_i, prev_addr, rv;
   logic [6:0] slave_addr_o;
   logic [7:0] mem [256];
   logic [7:0] d [4];
   logic [15:0] q [$];
   int errors = 0, total_checks = 0, gcr_cnt = 0, re_cnt = 0, str_cyc = 0;
   always #12.5 clk_i = ~clk_i;
   assign scl_w = !(scl_oe_o === 1'b1 || h_scl_low === 1'b1);
   assign sda_w = !(sda_oe_o === 1'b1 || h_sda_low === 1'b1);
   assign reg_rdata_i = mem[reg_addr_o];
   isp_i2c_slave #(.STRETCH_LIMIT(16)) u_dut (.clk_i(clk_i), .srst_i(srst_i), .scl_i(scl_w), .scl_o(scl_o),
      .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .asleep_i(asleep_i), .busy_i(busy_i),
      .irq_pending_i(irq_pending_i), .host_interrupt_line_n_o(irq_n), .addr_load_i(addr_load_i),
      .addr_new_i(addr_new_i), .no_inc_addr_i(8'hF0), .no_inc_en_i(no_inc_en_i), .reg_addr_o(reg_addr_o),
      .reg_wdata_o(reg_wdata_o), .reg_we_o(reg_we_o), .reg_re_o(reg_re_o), .reg_rdata_i(reg_rdata_i),
      .gen_call_reset_o(gen_call_reset_o), .slave_addr_o(slave_addr_o));
   isp_host_bfm u_host (.clk_i(clk_i), .scl_i(scl_w), .sda_i(sda_w), .scl_low_o(h_scl_low), .sda_low_o(h_sda_low));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks=%0d errors=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic xfer(input logic [7:0] b, input logic exp_ack);
      u_host.wr_byte(b, ack);
      chk({15'h0000, ack}, {15'h0000, exp_ack});
   endtask
   // write strobe carries the pointer of the cycle before, since it advances on the same edge
   always @(negedge clk_i)
   begin
      if (reg_we_o === 1'b1)
      begin
         chk({prev_addr, reg_wdata_o}, (q.size() != 0) ? q.pop_front() : 16'hXXXX);
         mem[prev_addr] = reg_wdata_o;
      end
      if (gen_call_reset_o === 1'b1)
         gcr_cnt++;
      if (reg_re_o === 1'b1)
         re_cnt++;
      if (scl_oe_o === 1'b1)
         str_cyc++;
      prev_addr = reg_addr_o;
   end
   initial
   begin
      #400000;
      errors++;
      test_done();
   end
   initial
   begin
      void'($urandom(77));
      foreach (mem[i])
         mem[i] = 8'($urandom);
      // stand-in registers have no reserved bits, so any data byte is legal
      foreach (d[i])
         d[i] = 8'($urandom);
      repeat (8) @(posedge clk_i);
      #1;
      srst_i = 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
      asleep_i = 1'b1;
      u_host.start();
      xfer(8'h88, 1'b0);
      u_host.stop();
      asleep_i = 1'b0;
      irq_pending_i = 1'($urandom);
      u_host.start();
      chk({15'h0000, irq_n}, {15'h0000, !irq_pending_i});
      xfer(8'h88, 1'b1);
      xfer(8'hAA, 1'b1);
      q.push_back({8'hAA, d[0]});
      xfer(d[0], 1'b1);
      q.push_back({8'hAB, d[1]});
      xfer(d[1], 1'b1);
      u_host.stop();
      u_host.start();
      xfer(8'h88, 1'b1);
      xfer(8'hAA, 1'b1);
      u_host.rstart();
      xfer(8'h89, 1'b1);
      u_host.rd_byte(1'b1, rv);
      chk({8'h00, rv}, {8'h00, d[0]});
      u_host.rd_byte(1'b0, rv);
      chk({8'h00, rv}, {8'h00, d[1]});
      u_host.stop();
      chk(16'(re_cnt), 16'h0002);
      chk(16'(str_cyc), 16'h0000);
      irq_pending_i = 1'($urandom);
      no_inc_en_i = 1'b1;
      busy_i = 1'b1;
      u_host.start();
      chk({15'h0000, irq_n}, {15'h0000, !irq_pending_i});
      xfer(8'h88, 1'b1);
      xfer(8'hF0, 1'b1);
      q.push_back({8'hF0, d[2]});
      xfer(d[2], 1'b1);
      q.push_back({8'hF0, d[3]});
      xfer(d[3], 1'b1);
      u_host.stop();
      chk(16'(str_cyc != 0), 16'h0001);
      busy_i = 1'b0;
      no_inc_en_i = 1'b0;
      addr_new_i = 7'h21;
      addr_load_i = 1'b1;
      @(posedge clk_i);
      #1;
      addr_load_i = 1'b0;
      irq_pending_i = 1'($urandom);
      u_host.start();
      chk({15'h0000, irq_n}, {15'h0000, !irq_pending_i});
      xfer(8'h88, 1'b0);
      u_host.stop();
      u_host.start();
      xfer(8'h42, 1'b1);
      u_host.stop();
      u_host.start();
      xfer(8'h00, 1'b1);
      xfer(8'h06, 1'b1);
      u_host.stop();
      chk({9'h000, slave_addr_o}, {9'h000, SLAVE_ADDR_DEFAULT});
      chk(16'(gcr_cnt), 16'h0001);
      u_host.start();
      xfer(8'h88, 1'b1);
      u_host.stop();
      chk(16'(q.size()), 16'h0000);
      test_done();
   end
endmodule
